// File: rtl/qsp_pkg.sv
// shared constants and state types for the burst-of-four memory port
// Notes on behaviour
// - write data captured on every rising edge of both input clocks while writing.
// - write port select is active low, sampled on positive clock, low starts write.
// - deselected write port ignores write data and leaves memory unchanged.
// - on 8-bit parts nibble select 0 gates bits 3..0, select 1 bits 7..4.
// - a high nibble select drops that nibble; stored nibble stays.
// - byte selects map to 9-bit lanes 8..0, 17..9, 26..18, 35..27.
// - each lane select is sampled on the same edge as its data beat.
// - a lane with deasserted select is not written; old value kept.
// - one shared address bus, sampled on positive clock rises for reads and writes.
// - four internal arrays; each address selects a four-word group.
// - address ignored on edges where the matching port select is inactive.
// - read port select is active low, sampled on positive clock, low starts read.
// - every read returns a burst of four consecutive words.
// - read words launched on rising edges of both input clocks.
// - deselected read port finishes burst; outputs float after next positive rise.
// - read valid flag marks valid output words, aligned with echo clocks.
// - transactions start on positive clock rise; both edges capture and launch.
// - two free-running echo clocks follow positive and negative input clocks.
// - loop disable low selects legacy single-latency mode, limited to 167 MHz.
package qsp_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int ADDR_W = 19;
  localparam int MEM_AW = 8;
  localparam int BURST = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_RESET = 0;
  // link edges between the read command edge and the first launched word
  localparam logic [1:0] LAT_EDGES_LOOP = 2'h3;
  localparam logic [1:0] LAT_EDGES_LEGACY = 2'h2;
  localparam logic [2:0] OUT_CNT_IDLE = 3'h4;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_BURST = 2'b10
  } qsp_wr_state_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_FETCH = 3'b010,
    RD_WAIT = 3'b100
  } qsp_rd_state_t;
endpackage

// File: rtl/qsp_buf_if.sv
// valid/ready carrier between the port logic and its write buffer
interface qsp_buf_if #(parameter int W = 8);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport buffer (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data);
  modport user (output push_valid, output push_data, output pop_ready,
                input push_ready, input pop_valid, input pop_data);
endinterface

// File: rtl/qsp_sync.sv
// two-stage synchroniser for a bundle of pin inputs
module qsp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // qsp_sync

// File: rtl/qsp_fifo.sv
// write beat buffer with parameterised width and depth
module qsp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic resetn,
  qsp_buf_if.buffer bif
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two >= 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  assign bif.push_ready = (wr_q - rd_q) != (PW + 1)'(DEPTH);
  assign bif.pop_valid = wr_q != rd_q;
  assign bif.pop_data = mem_q[rd_q[PW-1:0]];
  assign push = bif.push_valid && bif.push_ready;
  assign pop = bif.pop_valid && bif.pop_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= bif.push_data;
    end
  end
endmodule // qsp_fifo

// File: rtl/qsp_port.sv
// read/write port logic of the burst-of-four memory, sampled from clk
module qsp_port #(
  parameter int DW = qsp_pkg::DATA_W,
  parameter int LANE_W = qsp_pkg::LANE_W,
  parameter int ADDR_W = qsp_pkg::ADDR_W,
  parameter int MEM_AW = qsp_pkg::MEM_AW,
  parameter int FIFO_DEPTH = qsp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic k,
  input wire logic k_n,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic loop_disable_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DW-1:0] d,
  input wire logic [DW/LANE_W-1:0] byte_write_mask_n,
  output logic [DW-1:0] q,
  output logic q_oe,
  output logic read_valid_flag,
  output logic echo_clock,
  output logic echo_clock_n,
  output logic write_buf_ready
);
  localparam int LANES = DW / LANE_W;
  localparam int BURST = qsp_pkg::BURST;
  localparam int DEPTH = 1 << MEM_AW;
  localparam int FW = 2 + MEM_AW + LANES + DW;
  localparam int SW = 5 + ADDR_W + LANES + DW;

  if (LANES * LANE_W != DW) begin : g_bad_lanes
    $error("data width must be a whole number of lanes");
  end
  if (MEM_AW > ADDR_W || MEM_AW < 1) begin : g_bad_aw
    $error("stored address bits out of range");
  end

  // expands per-lane masks into per-bit masks; a set bit keeps the old data
  function automatic logic [DW-1:0] keep_bits(input logic [LANES-1:0] mask_n);
    logic [DW-1:0] res;
    res = '0;
    for (int l = 0; l < LANES; l++) begin
      res[l*LANE_W +: LANE_W] = {LANE_W{mask_n[l]}};
    end
    return res;
  endfunction

  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
      input logic [DW-1:0] new_w, input logic [LANES-1:0] mask_n);
    logic [DW-1:0] kb;
    kb = keep_bits(mask_n);
    return (old_w & kb) | (new_w & ~kb);
  endfunction

  // all pins, link clocks included, pass the same two stages so they stay aligned
  logic [SW-1:0] syn;
  logic k_s, kn_s, wps_s, rps_s, loop_disable_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [LANES-1:0] mask_s;
  logic [DW-1:0] d_s;

  qsp_sync #(.W(SW)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({k, k_n, write_port_select_n, read_port_select_n, loop_disable_n,
          addr, byte_write_mask_n, d}),
    .dout(syn)
  );
  assign {k_s, kn_s, wps_s, rps_s, loop_disable_n_s, addr_s, mask_s, d_s} = syn;

  logic k_prev_q, kn_prev_q, k_rise, kn_rise, any_edge;
  assign k_rise = k_s && !k_prev_q;
  assign kn_rise = kn_s && !kn_prev_q;
  assign any_edge = k_rise || kn_rise;

  qsp_buf_if #(.W(FW)) bif ();

  qsp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .bif(bif)
  );

  // write capture: four beats on alternating edges, one buffered entry each
  qsp_pkg::qsp_wr_state_t wr_state_q, wr_state_d;
  logic [1:0] wr_beat_q, wr_beat_d;
  logic [MEM_AW-1:0] wr_addr_q, wr_addr_d;

  always_comb begin
    wr_state_d = wr_state_q;
    wr_beat_d = wr_beat_q;
    wr_addr_d = wr_addr_q;
    bif.push_valid = 1'b0;
    bif.push_data = {wr_beat_q, wr_addr_q, mask_s, d_s};
    unique case (wr_state_q)
      qsp_pkg::WR_IDLE: begin
        if (k_rise && !wps_s) begin
          bif.push_valid = 1'b1;
          bif.push_data = {2'h0, addr_s[MEM_AW-1:0], mask_s, d_s};
          wr_addr_d = addr_s[MEM_AW-1:0];
          wr_beat_d = 2'h1;
          wr_state_d = qsp_pkg::WR_BURST;
        end
      end
      qsp_pkg::WR_BURST: begin
        if (any_edge) begin
          bif.push_valid = 1'b1;
          wr_beat_d = wr_beat_q + 2'h1;
          if (wr_beat_q == 2'h3) begin
            wr_state_d = qsp_pkg::WR_IDLE;
          end
        end
      end
    endcase
  end

  // the four arrays, one per burst position, each word split into lanes
  logic [DW-1:0] mem_q [BURST][DEPTH];
  qsp_pkg::qsp_rd_state_t rd_state_q, rd_state_d;
  logic [1:0] p_beat;
  logic [MEM_AW-1:0] p_addr;
  logic [LANES-1:0] p_mask;
  logic [DW-1:0] p_data, mem_old, mem_wr_d;
  logic pop_fire;

  assign {p_beat, p_addr, p_mask, p_data} = bif.pop_data;
  // arrays are single ported: a read fetch stalls the write drain
  assign bif.pop_ready = rd_state_q != qsp_pkg::RD_FETCH;
  assign pop_fire = bif.pop_valid && bif.pop_ready;
  assign mem_old = mem_q[p_beat][p_addr];
  assign mem_wr_d = lane_merge(mem_old, p_data, p_mask);

  always_ff @(posedge clk) begin
    if (pop_fire) begin
      mem_q[p_beat][p_addr] <= mem_wr_d;
    end
  end

  // read command, fetch of the whole group, then wait for the launch edge
  logic [MEM_AW-1:0] rd_addr_q, rd_addr_d;
  logic [1:0] rd_wait_q, rd_wait_d;
  logic [DW-1:0] rd_buf_q [BURST];
  logic [DW-1:0] rd_buf_d [BURST];
  logic launch;

  always_comb begin
    rd_state_d = rd_state_q;
    rd_addr_d = rd_addr_q;
    rd_wait_d = rd_wait_q;
    rd_buf_d = rd_buf_q;
    launch = 1'b0;
    unique case (rd_state_q)
      qsp_pkg::RD_IDLE: begin
        if (k_rise && !rps_s) begin
          rd_addr_d = addr_s[MEM_AW-1:0];
          rd_wait_d = loop_disable_n_s ? qsp_pkg::LAT_EDGES_LOOP : qsp_pkg::LAT_EDGES_LEGACY;
          rd_state_d = qsp_pkg::RD_FETCH;
        end
      end
      qsp_pkg::RD_FETCH: begin
        for (int i = 0; i < BURST; i++) begin
          rd_buf_d[i] = mem_q[i][rd_addr_q];
        end
        if (any_edge) begin
          rd_wait_d = rd_wait_q - 2'h1;
        end
        rd_state_d = qsp_pkg::RD_WAIT;
      end
      qsp_pkg::RD_WAIT: begin
        if (any_edge) begin
          if (rd_wait_q == 2'h1) begin
            launch = 1'b1;
            rd_state_d = qsp_pkg::RD_IDLE;
          end else begin
            rd_wait_d = rd_wait_q - 2'h1;
          end
        end
      end
    endcase
  end

  // output stage: one word per link edge, drivers released on a positive rise
  logic [DW-1:0] out_buf_q [BURST];
  logic [DW-1:0] out_buf_d [BURST];
  logic [2:0] out_cnt_q, out_cnt_d;
  logic [DW-1:0] q_d;
  logic q_oe_d, vld_d;

  always_comb begin
    out_buf_d = out_buf_q;
    out_cnt_d = out_cnt_q;
    q_d = q;
    q_oe_d = q_oe;
    vld_d = read_valid_flag;
    if (launch) begin
      out_buf_d = rd_buf_q;
      q_d = rd_buf_q[0];
      q_oe_d = 1'b1;
      vld_d = 1'b1;
      out_cnt_d = 3'h1;
    end else if (any_edge) begin
      if (out_cnt_q != qsp_pkg::OUT_CNT_IDLE) begin
        q_d = out_buf_q[out_cnt_q[1:0]];
        out_cnt_d = out_cnt_q + 3'h1;
      end else begin
        vld_d = 1'b0;
        if (k_rise) begin
          q_oe_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      k_prev_q <= 1'b0;
      kn_prev_q <= 1'b0;
      wr_state_q <= qsp_pkg::WR_IDLE;
      wr_beat_q <= 2'h0;
      wr_addr_q <= '0;
      rd_state_q <= qsp_pkg::RD_IDLE;
      rd_addr_q <= '0;
      rd_wait_q <= 2'h0;
      rd_buf_q <= '{default: '0};
      out_buf_q <= '{default: '0};
      out_cnt_q <= qsp_pkg::OUT_CNT_IDLE;
      q <= '0;
      q_oe <= 1'b0;
      read_valid_flag <= 1'b0;
      echo_clock <= 1'b0;
      echo_clock_n <= 1'b0;
      write_buf_ready <= 1'b0;
    end else begin
      k_prev_q <= k_s;
      kn_prev_q <= kn_s;
      wr_state_q <= wr_state_d;
      wr_beat_q <= wr_beat_d;
      wr_addr_q <= wr_addr_d;
      rd_state_q <= rd_state_d;
      rd_addr_q <= rd_addr_d;
      rd_wait_q <= rd_wait_d;
      rd_buf_q <= rd_buf_d;
      out_buf_q <= out_buf_d;
      out_cnt_q <= out_cnt_d;
      q <= q_d;
      q_oe <= q_oe_d;
      read_valid_flag <= vld_d;
      echo_clock <= k_s;
      echo_clock_n <= kn_s;
      write_buf_ready <= bif.push_ready;
    end
  end

  // checks
  a_wr_desel_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (wr_state_q == qsp_pkg::WR_IDLE && !(k_rise && !wps_s)) |-> !bif.push_valid)
    else $error("write beat taken while write port deselected");
  a_wr_start_k: assert property (@(posedge clk) disable iff (!resetn)
    $rose(wr_state_q == qsp_pkg::WR_BURST) |-> $past(k_rise) && !$past(wps_s))
    else $error("write burst started without positive rise and select");
  a_wr_beat_edge: assert property (@(posedge clk) disable iff (!resetn)
    (wr_state_q == qsp_pkg::WR_BURST && any_edge) |-> bif.push_valid
      && bif.push_data[DW+LANES+MEM_AW +: 2] == wr_beat_q)
    else $error("write beat missed on a link edge");
  a_lane_keep: assert property (@(posedge clk) disable iff (!resetn)
    pop_fire |-> ((mem_wr_d ^ mem_old) & keep_bits(p_mask)) == '0)
    else $error("masked lane changed in memory");
  a_lane_write: assert property (@(posedge clk) disable iff (!resetn)
    pop_fire |-> ((mem_wr_d ^ p_data) & ~keep_bits(p_mask)) == '0)
    else $error("enabled lane not written with its beat");
  a_rd_start_k: assert property (@(posedge clk) disable iff (!resetn)
    $rose(rd_state_q == qsp_pkg::RD_FETCH) |-> $past(k_rise) && !$past(rps_s))
    else $error("read started without positive rise and select");
  a_rd_addr_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(rd_state_q == qsp_pkg::RD_IDLE && k_rise && !rps_s) |=> $stable(rd_addr_q))
    else $error("read address taken while read port deselected");
  a_rd_latency: assert property (@(posedge clk) disable iff (!resetn)
    (rd_state_q == qsp_pkg::RD_IDLE && k_rise && !rps_s) |=> rd_wait_q ==
      ($past(loop_disable_n_s) ? qsp_pkg::LAT_EDGES_LOOP : qsp_pkg::LAT_EDGES_LEGACY))
    else $error("read latency does not follow loop disable");
  a_launch_first: assert property (@(posedge clk) disable iff (!resetn)
    launch |=> read_valid_flag && q_oe && q == $past(rd_buf_q[0]))
    else $error("first read word not launched with valid");
  a_burst_four: assert property (@(posedge clk) disable iff (!resetn)
    (any_edge && !launch && out_cnt_q == 3'h3) |=> read_valid_flag
      && out_cnt_q == qsp_pkg::OUT_CNT_IDLE)
    else $error("read burst not four words long");
  a_oe_off_k: assert property (@(posedge clk) disable iff (!resetn)
    $fell(q_oe) |-> $past(k_rise) && $past(out_cnt_q) == qsp_pkg::OUT_CNT_IDLE)
    else $error("read drivers released off a positive rise or mid burst");
  a_valid_echo: assert property (@(posedge clk) disable iff (!resetn)
    $changed(read_valid_flag) |-> ($changed(echo_clock) || $changed(echo_clock_n)))
    else $error("valid flag moved apart from echo clocks");

  c_write_burst: cover property (@(posedge clk) disable iff (!resetn)
    pop_fire && p_beat == 2'h3 && p_mask != '0);
  c_read_burst: cover property (@(posedge clk) disable iff (!resetn)
    $fell(read_valid_flag));
  c_legacy_read: cover property (@(posedge clk) disable iff (!resetn)
    launch && k_rise);
  c_drain_stall: cover property (@(posedge clk) disable iff (!resetn)
    bif.pop_valid && !bif.pop_ready);
endmodule // qsp_port

// File: tb/qsp_ctl_model.sv
// controller-side model: link clocks and burst driver for the memory port
module qsp_ctl_model (
  input wire logic clk,
  output logic k,
  output logic k_n,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [qsp_pkg::ADDR_W-1:0] addr,
  output logic [qsp_pkg::DATA_W-1:0] d,
  output logic [3:0] byte_write_mask_n,
  input wire logic [qsp_pkg::DATA_W-1:0] q,
  input wire logic q_oe,
  input wire logic read_valid_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // q floats whenever the port does not drive it
  wire [qsp_pkg::DATA_W-1:0] q_seen = q_oe ? q : 'z;
  time t_free = 0;

  initial begin
    k = 1'b0;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    addr = '0;
    d = '0;
    byte_write_mask_n = 4'hF;
    forever begin
      #400 k = ~k;
    end
  end
  assign k_n = ~k;

  // present just before a k rise, unless a burst has just ended there
  task automatic align();
    if ($time != t_free) begin
      @(posedge k_n);
      #200;
    end
  endtask

  task automatic write_burst(input logic [qsp_pkg::ADDR_W-1:0] a,
                             input logic [3:0][qsp_pkg::DATA_W-1:0] w,
                             input logic [3:0][3:0] m);
    align();
    for (int i = 0; i < 4; i++) begin
      write_port_select_n = (i != 0);
      addr = (i == 0) ? a : ~a;
      d = w[i];
      byte_write_mask_n = m[i];
      if (i % 2 == 0) @(posedge k);
      else @(posedge k_n);
      #200;
    end
    t_free = $time;
  endtask

  // selects stay high while data and address change on every edge
  task automatic noise(input logic [3:0][qsp_pkg::DATA_W-1:0] v,
                       input logic [3:0][qsp_pkg::ADDR_W-1:0] a);
    align();
    for (int i = 0; i < 4; i++) begin
      d = v[i];
      addr = a[i];
      byte_write_mask_n = 4'h0;
      if (i % 2 == 0) @(posedge k);
      else @(posedge k_n);
      #200;
    end
    t_free = $time;
  endtask

  task automatic read_burst(input logic [qsp_pkg::ADDR_W-1:0] a,
                            output logic [3:0][qsp_pkg::DATA_W-1:0] w,
                            output int lat, output logic vld_end, output int oe_wait);
    align();
    read_port_select_n = 1'b0;
    addr = a;
    // write data and masks move while the write port stays deselected
    d = ~d;
    byte_write_mask_n = ~byte_write_mask_n;
    @(posedge k);
    #200;
    read_port_select_n = 1'b1;
    addr = ~a;
    lat = 0;
    while (read_valid_flag !== 1'b1 && lat < 200) begin
      @(negedge clk);
      lat++;
    end
    for (int i = 0; i < 4; i++) begin
      w[i] = q_seen;
      repeat (4) @(negedge clk);
    end
    vld_end = read_valid_flag;
    oe_wait = 0;
    while (q_oe !== 1'b0 && oe_wait < 20) begin
      @(negedge clk);
      oe_wait++;
    end
  endtask
endmodule // qsp_ctl_model

// File: tb/quad_rate_sram_port_test.sv
// self-checking bench for the burst-of-four memory port
module quad_rate_sram_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DW = qsp_pkg::DATA_W;
  localparam int AW = qsp_pkg::ADDR_W;
  localparam int NA = 6;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic loop_disable_n = 1'b1;
  logic k, k_n, write_port_select_n, read_port_select_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] d, q;
  logic [3:0] byte_write_mask_n;
  logic q_oe, read_valid_flag, echo_clock, echo_clock_n, write_buf_ready;
  int bad_count = 0;
  int n_compared = 0;
  integer seed = 32'hB16D2E15;
  logic [DW-1:0] exp_mem [NA][4];
  logic [AW-1:0] adr [NA];

  always #50 clk = ~clk;

  qsp_port qsp_port_i (.clk(clk), .resetn(resetn), .k(k), .k_n(k_n),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .loop_disable_n(loop_disable_n), .addr(addr), .d(d),
    .byte_write_mask_n(byte_write_mask_n), .q(q), .q_oe(q_oe),
    .read_valid_flag(read_valid_flag), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n), .write_buf_ready(write_buf_ready));

  qsp_ctl_model qsp_ctl_model_i (.clk(clk), .k(k), .k_n(k_n),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .addr(addr), .d(d), .byte_write_mask_n(byte_write_mask_n), .q(q), .q_oe(q_oe),
    .read_valid_flag(read_valid_flag));

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // lanes whose mask bit is low take the new beat
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                          input logic [3:0] m);
    logic [DW-1:0] r;
    r = o;
    for (int l = 0; l < 4; l++) begin
      if (!m[l]) r[l*qsp_pkg::LANE_W +: qsp_pkg::LANE_W] = n[l*qsp_pkg::LANE_W +: qsp_pkg::LANE_W];
    end
    return r;
  endfunction

  // one beat of each masked burst is fully masked as a corner case
  task automatic wr(input int i, input bit masked);
    logic [3:0][DW-1:0] w;
    logic [3:0][3:0] m;
    for (int b = 0; b < 4; b++) begin
      w[b] = DW'({$random(seed), $random(seed)});
      m[b] = !masked ? 4'h0 : (b == i % 4) ? 4'hF : 4'($random(seed));
      exp_mem[i][b] = merge(exp_mem[i][b], w[b], m[b]);
    end
    qsp_ctl_model_i.write_burst(adr[i], w, m);
  endtask

  task automatic rd(input int i, output int lat);
    logic [3:0][DW-1:0] w;
    logic ve;
    int ow;
    qsp_ctl_model_i.read_burst(adr[i], w, lat, ve, ow);
    check(lat < 200, 1'b1);
    if (lat >= 200) tally_and_finish();
    for (int b = 0; b < 4; b++) check(w[b], exp_mem[i][b]);
    check(ve, 1'b0);
    check(ow <= 4, 1'b1);
  endtask

  task automatic rd_all();
    int lat;
    for (int i = 0; i < NA; i++) rd(i, lat);
  endtask

  initial begin
    logic [3:0][DW-1:0] nv;
    logic [3:0][AW-1:0] na;
    int la, lb, ra, rb;
    logic e0, e1;
    repeat (5) @(negedge clk);
    check(q_oe, 1'b0);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    check(write_buf_ready, 1'b1);
    for (int i = 0; i < NA; i++) adr[i] = {(AW-8)'($random(seed)), 8'(i * 41 + 3)};
    for (int i = 0; i < NA; i++) wr(i, 1'b0);
    rd_all();
    $display("full burst writes done");
    for (int i = 0; i < NA; i++) wr(i, 1'b1);
    rd_all();
    $display("masked burst writes done");
    for (int b = 0; b < 4; b++) begin
      nv[b] = DW'({$random(seed), $random(seed)});
      na[b] = adr[b];
    end
    qsp_ctl_model_i.noise(nv, na);
    rd_all();
    $display("deselected noise done");
    rd(0, la);
    @(negedge clk);
    loop_disable_n = 1'b0;
    rd(1, lb);
    check(la - lb, (qsp_pkg::LAT_EDGES_LOOP - qsp_pkg::LAT_EDGES_LEGACY) * 4);
    @(negedge clk);
    loop_disable_n = 1'b1;
    $display("latency modes done");
    ra = 0;
    rb = 0;
    e0 = echo_clock;
    e1 = echo_clock_n;
    for (int c = 0; c < 32; c++) begin
      @(negedge clk);
      if (echo_clock && !e0) ra++;
      if (echo_clock_n && !e1) rb++;
      e0 = echo_clock;
      e1 = echo_clock_n;
    end
    check(ra, 4);
    check(rb, 4);
    $display("echo clocks done");
    tally_and_finish();
  end
endmodule // quad_rate_sram_port_test
